// ==== core/line_if.sv ====
// Per-line sample bundle between the line sampler and the decoder.
`timescale 1ns/1ps
interface line_if;
    logic       strobe;
    logic       mark;
    logic [2:0] info;
    logic       reverse;
    modport src (output strobe, output mark, output info, input reverse);
    modport dst (input strobe, input mark, input info, output reverse);
endinterface : line_if

// ==== core/tape_defines.svh ====
// Constant definitions for the tape mark-track decoder.
`ifndef TAPE_DEFINES_SVH
`define TAPE_DEFINES_SVH

// Forward mark codes as recorded; octal figures in the comments.
`define MK_REV_END     6'h2D
`define MK_EXPAND      6'h15
`define MK_BLOCK       6'h16
`define MK_REV_GUARD   6'h1A
`define MK_LOCK        6'h08
`define MK_DATA        6'h38
`define MK_FINAL       6'h3B
`define MK_COUNT       7

// Frame geometry: six lines of three bits make one word.
`define LINES_PER_FRAME 6
`define BITS_PER_LINE   3
`define FRAME_LAST      3'h5

// Position of the checksum frame within a run of octal 73 frames.
`define CSUM_RUN_FWD    2'h3
`define CSUM_RUN_REV    2'h1
`define RUN_MAX         2'h3

// Standard tape layout and block numbering limit.
`define STD_BLOCKS      576
`define STD_WORDS       256
`define MAX_BLOCKS      4096

`endif

// ==== core/tape_line_sampler.sv ====
// Timing-track driven sampler that yields one strobe per tape line.
`timescale 1ns/1ps
module tape_line_sampler #(
    parameter int CNT_W = 12
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       timing_in,
    input  wire logic       mark_in,
    input  wire logic [2:0] info_in,
    line_if.src             ln
);
    logic [4:0]       sync1_q;
    logic [4:0]       sync2_q;
    logic             t_prev_q;
    logic [CNT_W-1:0] run_q;
    logic [CNT_W-1:0] half_q;
    logic             armed_q;
    logic             strobe_q;
    logic             mark_q;
    logic [2:0]       info_q;
    logic             edge_w;
    logic             fire_w;

    // Two-stage synchronisers; only the second stage feeds logic.
    always_ff @(posedge clock) begin
        if (rst) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
        end else begin
            sync1_q <= {timing_in, mark_in, info_in}; // R01
            sync2_q <= sync1_q;
        end
    end

    assign edge_w = sync2_q[4] ^ t_prev_q;
    assign fire_w = armed_q && !edge_w && (run_q == {1'b0, half_q[CNT_W-1:1]});

    // Half-period measurement follows tape speed instead of a fixed rate.
    always_ff @(posedge clock) begin
        if (rst) begin
            t_prev_q <= 1'b0;
            run_q    <= '0;
            half_q   <= '0;
        end else begin
            t_prev_q <= sync2_q[4];
            if (edge_w) begin
                run_q  <= '0;
                half_q <= run_q; // R06
            end else if (run_q != {CNT_W{1'b1}}) begin
                run_q <= run_q + 1'b1;
            end
        end
    end

    // Arm on entry to the correct polarity, which flips with direction.
    always_ff @(posedge clock) begin
        if (rst) begin
            armed_q  <= 1'b0;
            strobe_q <= 1'b0;
            mark_q   <= 1'b0;
            info_q   <= 3'h0;
        end else begin
            strobe_q <= fire_w;
            if (edge_w) begin
                armed_q <= (sync2_q[4] != ln.reverse);
            end else if (fire_w) begin
                armed_q <= 1'b0;
            end
            if (fire_w) begin
                mark_q <= sync2_q[3]; // R02
                info_q <= sync2_q[2:0]; // R10
            end
        end
    end

    assign ln.strobe = strobe_q;
    assign ln.mark   = mark_q;
    assign ln.info   = info_q;

    property p_strobe_polarity;
        @(posedge clock) disable iff (rst)
        strobe_q |-> ($past(sync2_q[4]) != $past(ln.reverse));
    endproperty
    a_strobe_polarity: assert property (p_strobe_polarity) // R10
        else $error("Line sampled outside the correct timing polarity.");
endmodule : tape_line_sampler

// ==== core/tape_mark_track_decoder.sv ====
// Mark-track decoder and word framer for a block-addressable tape.
// Summary of operation
// R01: Ten head tracks arrive as five redundant channels: timing, mark, three info.
// R02: All channels are phase encoded and sensed by polarity.
// R03: Standard tape holds 576 blocks of 256 eighteen-bit words.
// R04: Each data word is six lines of three information bits.
// R05: Block numbers cover up to 4096 blocks.
// R06: Line timing comes from the timing channel, immune to speed drift.
// R07: Six-bit mark codes are shifted in serially, one bit at a time.
// R08: Outside preformatting exactly one mark bit is taken per line.
// R09: Six lines form one mark frame; its six mark bits form one code.
// R10: Samples are taken at the centre of the correct timing polarity.
// R11: In reverse, codes arrive bit-reversed and inverted.
// R12: Codes are recognised in hardware and gate word transfers.
// R13: Codes drive flags, data requests, block numbers, ends, protected regions.
// R14: Decoding gives direction independence, variable blocks, end-of-tape sensing.
// R15: Block length follows the recorded marks, never a fixed count.
// R16: Read and write work in either direction.
// R17: Write position is located from mark and timing information.
// R18: Octal 26 marks block start and publishes the block number.
// R19: Octal 70 marks a frame holding a data word.
// R20: Octal 55 marks travel from the end zone toward the blocks.
// R21: Checksum frame is written on writes and compared on reads; reverse writes put the sum in the third octal 73 frame met.
// R22: Reverse matching compares against the complement image of every code.
// R23: Frame alignment is held once found until a frame fails to decode.
`timescale 1ns/1ps
`include "tape_defines.svh"
module tape_mark_track_decoder #(
    parameter int WORD_W  = 18,
    parameter int BLOCK_W = 12,
    parameter int WCNT_W  = 9,
    parameter int CNT_W   = 12
) (
    input  wire logic               CLOCK,
    input  wire logic               RST,
    input  wire logic               TIMING_IN,
    input  wire logic               MARK_IN,
    input  wire logic [2:0]         INFO_IN,
    input  wire logic               DIR_REVERSE,
    input  wire logic               WRITE_MODE,
    input  wire logic               PREFORMAT,
    input  wire logic [WORD_W-1:0]  WR_WORD,
    output logic                    ALIGNED,
    output logic [5:0]              MARK_CODE,
    output logic                    BLOCK_FLAG,
    output logic [BLOCK_W-1:0]      BLOCK_NUM,
    output logic                    END_FLAG,
    output logic                    DATA_REQ,
    output logic [WORD_W-1:0]       DATA_WORD,
    output logic [WCNT_W-1:0]       WORD_COUNT,
    output logic                    PROTECT,
    output logic                    CHECK_ERR,
    output logic [2:0]              WR_INFO,
    output logic                    WR_EN
);
    // Elaboration checks on parameters the framing cannot serve.
    if (WORD_W != `LINES_PER_FRAME * `BITS_PER_LINE) begin : g_bad_word
        $error("WORD_W must equal six lines of three bits.");
    end
    if (BLOCK_W < 1 || (1 << BLOCK_W) > `MAX_BLOCKS) begin : g_bad_block
        $error("BLOCK_W must address at most 4096 blocks.");
    end
    if ((1 << WCNT_W) <= `STD_WORDS || CNT_W < 4) begin : g_bad_count
        $error("WCNT_W must count a standard block and CNT_W must be at least 4.");
    end

    localparam logic [6*`MK_COUNT-1:0] CODE_LIST = {`MK_REV_END, `MK_EXPAND, `MK_BLOCK,
        `MK_REV_GUARD, `MK_LOCK, `MK_DATA, `MK_FINAL};

    line_if ln ();
    assign ln.reverse = DIR_REVERSE;

    tape_line_sampler #(
        .CNT_W     (CNT_W)
    ) u_sampler (
        .clock     (CLOCK),
        .rst       (RST),
        .timing_in (TIMING_IN),
        .mark_in   (MARK_IN),
        .info_in   (INFO_IN),
        .ln        (ln)
    );

    // Image of a forward code as seen with the tape running backwards.
    function automatic tape_pkg::mark_t image(input tape_pkg::mark_t code, input logic rev);
        tape_pkg::mark_t r;
        r = code;
        for (int i = 0; i < 6; i++) begin
            r[i] = ~code[5-i];
        end
        return rev ? r : code;
    endfunction : image

    // Search the code list; the result carries a hit bit over the forward code.
    function automatic logic [6:0] lookup(input tape_pkg::mark_t frame, input logic rev);
        logic [6:0] res;
        res = 7'h00;
        for (int i = 0; i < `MK_COUNT; i++) begin
            if (frame == image(CODE_LIST[6*i +: 6], rev)) begin
                res = {1'b1, CODE_LIST[6*i +: 6]}; // R22
            end
        end
        return res;
    endfunction : lookup

    tape_pkg::align_e   state_q;
    logic [2:0]         line_cnt_q;
    tape_pkg::mark_t    mark_sr_q;
    tape_pkg::word_t    info_sr_q;
    logic [1:0]         run73_q;
    tape_pkg::word_t    csum_q;
    tape_pkg::word_t    csum_ref_q;
    logic               csum_pend_q;
    logic               wr_arm_q;
    tape_pkg::word_t    wr_buf_q;
    tape_pkg::word_t    wr_word_q;
    tape_pkg::mark_t    sr_next;
    tape_pkg::word_t    info_next;
    tape_pkg::word_t    word_fix;
    logic [6:0]         dec;
    logic               hit;
    tape_pkg::mark_t    code;
    logic               frame_end;
    logic               good;
    logic [1:0]         run73_d;
    logic               is_csum;
    logic               is_data;
    logic               wr_next;
    tape_pkg::word_t    csum_d;

    assign sr_next   = {mark_sr_q[4:0], ln.mark};
    assign info_next = {info_sr_q[WORD_W-4:0], ln.info};
    assign dec       = lookup(sr_next, DIR_REVERSE); // R14
    assign hit       = dec[6];
    assign code      = dec[5:0];

    // Reverse words arrive last line first and inverted; restore forward order.
    for (genvar g = 0; g < `LINES_PER_FRAME; g++) begin : g_word
        assign word_fix[3*g +: 3] = DIR_REVERSE ? ~info_next[3*(5-g) +: 3] : info_next[3*g +: 3];
    end

    // Frame boundaries: any hit while searching, every sixth line once locked.
    always_comb begin
        frame_end = 1'b0;
        if (ln.strobe && !PREFORMAT) begin
            frame_end = (state_q == tape_pkg::ALIGN_SEARCH) ? hit : (line_cnt_q == `FRAME_LAST); // R09
        end
        good    = frame_end && hit;
        run73_d = 2'h0;
        if (code == `MK_FINAL) begin
            run73_d = (run73_q == `RUN_MAX) ? `RUN_MAX : run73_q + 2'h1;
        end
        is_csum = good && (code == `MK_FINAL) &&
                  (run73_d == (DIR_REVERSE ? `CSUM_RUN_REV : `CSUM_RUN_FWD));
        is_data = good && ((code == `MK_DATA) || ((code == `MK_FINAL) && !is_csum)); // R19
        csum_d  = csum_q ^ ((WRITE_MODE && wr_arm_q) ? wr_word_q : word_fix);
        wr_next = good && WRITE_MODE && ((code == `MK_DATA) || ((code == `MK_FINAL) && (run73_d < `RUN_MAX)));
    end

    // Mark and information shift registers, one mark bit and three info bits per line.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            mark_sr_q <= 6'h00;
            info_sr_q <= 18'h00000;
        end else if (ln.strobe && !PREFORMAT) begin
            mark_sr_q <= sr_next; // R07
            info_sr_q <= info_next; // R04
        end
    end

    // Alignment is kept across frames and dropped only on an unknown code or on preformatting.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state_q    <= tape_pkg::ALIGN_SEARCH;
            line_cnt_q <= 3'h0;
        end else if (PREFORMAT) begin
            state_q    <= tape_pkg::ALIGN_SEARCH;
            line_cnt_q <= 3'h0;
        end else if (ln.strobe) begin
            unique case (state_q)
                tape_pkg::ALIGN_SEARCH: begin
                    if (hit) begin
                        state_q    <= tape_pkg::ALIGN_LOCKED;
                        line_cnt_q <= 3'h0;
                    end
                end
                tape_pkg::ALIGN_LOCKED: begin
                    if (line_cnt_q == `FRAME_LAST) begin
                        line_cnt_q <= 3'h0;
                        if (!hit) begin
                            state_q <= tape_pkg::ALIGN_SEARCH; // R23
                        end
                    end else begin
                        line_cnt_q <= line_cnt_q + 3'h1; // R08
                    end
                end
            endcase
        end
    end

    // Decoded codes become flags, data requests and block information.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            ALIGNED    <= 1'b0;
            MARK_CODE  <= 6'h00;
            BLOCK_FLAG <= 1'b0;
            BLOCK_NUM  <= '0;
            END_FLAG   <= 1'b0;
            DATA_REQ   <= 1'b0;
            DATA_WORD  <= '0;
            PROTECT    <= 1'b0;
        end else begin
            ALIGNED    <= (state_q == tape_pkg::ALIGN_LOCKED);
            BLOCK_FLAG <= good && (code == `MK_BLOCK); // R18
            END_FLAG   <= good && (code == `MK_REV_END); // R20
            DATA_REQ   <= is_data; // R12
            if (good) begin
                MARK_CODE <= code; // R11
                PROTECT   <= (code == `MK_LOCK) || (code == `MK_REV_GUARD); // R13
            end
            if (good && (code == `MK_BLOCK)) begin
                BLOCK_NUM <= word_fix[BLOCK_W-1:0]; // R05
            end
            if (is_data) begin
                DATA_WORD <= word_fix;
            end
        end
    end

    // Word count per block comes from the marks alone, so any length works up to the all-ones count, where it saturates.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            WORD_COUNT <= '0;
            run73_q    <= 2'h0;
        end else if (good) begin
            run73_q <= run73_d;
            if (code == `MK_BLOCK) begin
                WORD_COUNT <= '0; // R15
            end else if (is_data && (WORD_COUNT != {WCNT_W{1'b1}})) begin
                WORD_COUNT <= WORD_COUNT + 1'b1; // R03
            end
        end
    end

    // Longitudinal checksum; reverse travel meets the stored value first.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            csum_q      <= 18'h00000;
            csum_ref_q  <= 18'h00000;
            csum_pend_q <= 1'b0;
            CHECK_ERR   <= 1'b0;
        end else if (good) begin
            if (code == `MK_BLOCK) begin
                CHECK_ERR <= 1'b0;
            end
            if (is_data) begin
                csum_q <= csum_d;
            end else if (code == `MK_LOCK) begin
                csum_q <= 18'h00000;
            end
            if (is_csum && !DIR_REVERSE) begin
                csum_q <= 18'h00000;
                if (!WRITE_MODE && (word_fix != csum_q)) begin
                    CHECK_ERR <= 1'b1; // R21
                end
            end else if (is_csum) begin
                csum_q      <= 18'h00000;
                csum_ref_q  <= word_fix;
                csum_pend_q <= !WRITE_MODE;
            end else if (csum_pend_q && !is_data) begin
                csum_pend_q <= 1'b0;
                if (csum_q != csum_ref_q) begin
                    CHECK_ERR <= 1'b1; // R21
                end
            end
        end
    end

    // Writes land in the frame after a data mark; the sixth line goes out on the same edge that reloads the buffer.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            wr_arm_q  <= 1'b0;
            wr_buf_q  <= 18'h00000;
            wr_word_q <= 18'h00000;
            WR_INFO   <= 3'h0;
            WR_EN     <= 1'b0;
        end else begin
            if (ln.strobe && wr_arm_q) begin
                if (DIR_REVERSE) begin
                    WR_INFO  <= ~wr_buf_q[2:0]; // R16
                    wr_buf_q <= {3'h0, wr_buf_q[WORD_W-1:3]};
                end else begin
                    WR_INFO  <= wr_buf_q[WORD_W-1 -: 3];
                    wr_buf_q <= {wr_buf_q[WORD_W-4:0], 3'h0};
                end
            end
            if (frame_end) begin
                wr_arm_q  <= wr_next; // R17
                wr_word_q <= WR_WORD; // R21
                wr_buf_q  <= (run73_d == 2'h2) ? (is_data ? csum_d : csum_q) : WR_WORD;
            end
            WR_EN <= wr_arm_q && !PREFORMAT;
        end
    end

    // Helper image of the last decoded code for the direction check.
    tape_pkg::mark_t seen_q;
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            seen_q <= 6'h00;
        end else if (good) begin
            seen_q <= sr_next;
        end
    end

    property p_block_code;
        @(posedge CLOCK) disable iff (RST)
        BLOCK_FLAG |-> (MARK_CODE == `MK_BLOCK);
    endproperty
    a_block_code: assert property (p_block_code) // R18
        else $error("Block flag without a block mark.");

    property p_data_code;
        @(posedge CLOCK) disable iff (RST)
        DATA_REQ |-> ((MARK_CODE == `MK_DATA) || (MARK_CODE == `MK_FINAL));
    endproperty
    a_data_code: assert property (p_data_code) // R19
        else $error("Data request without a data-bearing mark.");

    property p_end_code;
        @(posedge CLOCK) disable iff (RST)
        END_FLAG |-> (MARK_CODE == `MK_REV_END) && !BLOCK_FLAG && !DATA_REQ;
    endproperty
    a_end_code: assert property (p_end_code) // R20
        else $error("End flag without an end mark.");

    property p_flag_pulse;
        @(posedge CLOCK) disable iff (RST)
        BLOCK_FLAG |=> !BLOCK_FLAG [*2];
    endproperty
    a_flag_pulse: assert property (p_flag_pulse) // R13
        else $error("Block flag longer than one cycle.");

    property p_line_range;
        @(posedge CLOCK) disable iff (RST)
        line_cnt_q <= `FRAME_LAST;
    endproperty
    a_line_range: assert property (p_line_range) // R09
        else $error("Line counter beyond one frame.");

    property p_lose_align;
        @(posedge CLOCK) disable iff (RST)
        (state_q == tape_pkg::ALIGN_LOCKED && ln.strobe && !PREFORMAT && line_cnt_q == `FRAME_LAST && !hit)
        |=> (state_q == tape_pkg::ALIGN_SEARCH) ##1 !ALIGNED;
    endproperty
    a_lose_align: assert property (p_lose_align) // R23
        else $error("Alignment kept after an unknown frame.");

    property p_hold_align;
        @(posedge CLOCK) disable iff (RST)
        (state_q == tape_pkg::ALIGN_LOCKED && !PREFORMAT && !(ln.strobe && line_cnt_q == `FRAME_LAST))
        |=> (state_q == tape_pkg::ALIGN_LOCKED);
    endproperty
    a_hold_align: assert property (p_hold_align) // R23
        else $error("Alignment dropped inside a frame.");

    property p_shift_bit;
        @(posedge CLOCK) disable iff (RST)
        (ln.strobe && !PREFORMAT) |=> (mark_sr_q[0] == $past(ln.mark)) && (mark_sr_q[5:1] == $past(mark_sr_q[4:0]));
    endproperty
    a_shift_bit: assert property (p_shift_bit) // R07
        else $error("Mark bit not shifted in on a line.");

    property p_image;
        @(posedge CLOCK) disable iff (RST)
        (good && DIR_REVERSE && $stable(DIR_REVERSE)) |=> (image(MARK_CODE, 1'b1) == seen_q);
    endproperty
    a_image: assert property (p_image) // R11
        else $error("Reverse code is not the complement image of the reported code.");
endmodule : tape_mark_track_decoder

// ==== core/tape_pkg.sv ====
// Types shared by the tape mark-track decoder modules.
package tape_pkg;
    typedef enum logic {ALIGN_SEARCH, ALIGN_LOCKED} align_e;
    typedef logic [5:0]  mark_t;
    typedef logic [17:0] word_t;
endpackage : tape_pkg

// ==== tb/tape_head_model.sv ====
// Behavioural tape heads: plays mark frames on the channels and records the written lines.
`timescale 1ns/1ps
module tape_head_model (
    input  wire logic       dir_reverse,
    input  wire logic [2:0] wr_info,
    input  wire logic       wr_en,
    output logic            timing,
    output logic            mark,
    output logic [2:0]      info
);
    logic [3:0] wr_q[$];

    // Heads rest with every channel low until the tape moves.
    initial begin
        timing = 1'b0;
        mark   = 1'b0;
        info   = 3'h0;
    end

    // One six-line frame. The timing track only moves while frames play, so it stands still between calls.
    task automatic play(input logic [5:0] code, input logic [17:0] word);
        int k;
        for (k = 0; k < 6; k++) begin
            if (dir_reverse) begin
                mark = ~code[k];
                info = ~word[3*k +: 3];
            end else begin
                mark = code[5-k];
                info = word[15-3*k +: 3];
            end
            timing = dir_reverse;
            #200;
            wr_q.push_back({wr_en, wr_info}); // Written bits of the previous line are settled here.
            timing = ~dir_reverse;
            #200;
        end
    endtask : play
endmodule : tape_head_model

// ==== tb/tape_mark_track_decoder_test.sv ====
// Self-checking bench for the tape mark-track decoder.
`timescale 1ns/1ps
module tape_mark_track_decoder_test;
    logic        CLOCK, RST, DIR_REVERSE, WRITE_MODE, PREFORMAT, TIMING_IN, MARK_IN;
    logic [2:0]  INFO_IN, WR_INFO;
    logic [17:0] WR_WORD, DATA_WORD;
    logic        ALIGNED, BLOCK_FLAG, END_FLAG, DATA_REQ, PROTECT, CHECK_ERR, WR_EN;
    logic [5:0]  MARK_CODE;
    logic [11:0] BLOCK_NUM;
    logic [8:0]  WORD_COUNT;
    logic [17:0] got_q[$], exp_q[$];
    logic [17:0] bn;
    int          miscompares, samples_checked, ends, blocks, k;
    int          seed = 32'hA522FE94;

    tape_mark_track_decoder dut (.CLOCK(CLOCK), .RST(RST), .TIMING_IN(TIMING_IN), .MARK_IN(MARK_IN),
        .INFO_IN(INFO_IN), .DIR_REVERSE(DIR_REVERSE), .WRITE_MODE(WRITE_MODE), .PREFORMAT(PREFORMAT),
        .WR_WORD(WR_WORD), .ALIGNED(ALIGNED), .MARK_CODE(MARK_CODE), .BLOCK_FLAG(BLOCK_FLAG),
        .BLOCK_NUM(BLOCK_NUM), .END_FLAG(END_FLAG), .DATA_REQ(DATA_REQ), .DATA_WORD(DATA_WORD),
        .WORD_COUNT(WORD_COUNT), .PROTECT(PROTECT), .CHECK_ERR(CHECK_ERR), .WR_INFO(WR_INFO), .WR_EN(WR_EN));

    tape_head_model head (.dir_reverse(DIR_REVERSE), .wr_info(WR_INFO), .wr_en(WR_EN),
        .timing(TIMING_IN), .mark(MARK_IN), .info(INFO_IN));

    // Free-running 20 MHz system clock.
    initial begin
        CLOCK = 1'b0;
        forever #25 CLOCK = ~CLOCK;
    end

    // Pulse outputs last one cycle, so they are collected on every edge.
    always @(posedge CLOCK) begin
        if (DATA_REQ === 1'b1) got_q.push_back(DATA_WORD);
        if (END_FLAG === 1'b1) ends++;
        if (BLOCK_FLAG === 1'b1) blocks++;
    end

    task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    // Lets the last line strobe and its decode land before levels are looked at.
    task automatic settle;
        repeat (12) @(negedge CLOCK);
    endtask : settle

    // Lock cells match no code at any other phase, so alignment settles on the true frame first.
    // End marks repeat every three lines and would let alignment lock half a frame off.
    task automatic preamble;
        repeat (5) head.play(6'h08, 18'h0);
        head.play(6'h2D, 18'h0);
        settle;
        check("aligned", 18'(ALIGNED), 18'h1);
        check("end code", 18'(MARK_CODE), 18'h2D);
        got_q.delete();
    endtask : preamble

    // Compares every requested word with what the heads played, in arrival order.
    task automatic drain;
        settle;
        check("word total", 18'(got_q.size()), 18'(exp_q.size()));
        while (exp_q.size() > 0 && got_q.size() > 0) check("word", got_q.pop_front(), exp_q.pop_front());
        exp_q.delete();
        got_q.delete();
    endtask : drain

    task automatic data_frame(input logic [5:0] code, inout logic [17:0] sum);
        logic [17:0] w;
        w = 18'($random(seed));
        sum ^= w;
        exp_q.push_back(w);
        head.play(code, w);
    endtask : data_frame

    // Forward block: start, guard, lock cells, five data, prefinal, final, checksum.
    task automatic fwd_block(input logic bad);
        logic [17:0] sum;
        sum = 18'h0;
        bn = 18'($random(seed));
        head.play(6'h16, bn);
        head.play(6'h1A, 18'h0);
        settle;
        check("guard protect", 18'(PROTECT), 18'h1);
        repeat (4) head.play(6'h08, 18'h0);
        for (k = 0; k < 7; k++) data_frame((k < 5) ? 6'h38 : 6'h3B, sum);
        head.play(6'h3B, bad ? ~sum : sum);
        head.play(6'h08, 18'h0);
        drain;
        check("check error", 18'(CHECK_ERR), 18'(bad));
        check("word count", 18'(WORD_COUNT), 18'h7);
        check("block number", 18'(BLOCK_NUM), 18'(bn[11:0]));
    endtask : fwd_block

    initial begin
        {RST, DIR_REVERSE, WRITE_MODE, PREFORMAT} = 4'h8;
        WR_WORD = 18'h0;
        repeat (3) @(negedge CLOCK);
        RST = 1'b0;
        preamble;
        fwd_block(1'b0);
        fwd_block(1'b1);
        head.play(6'h16, 18'h0);
        settle;
        check("error cleared", 18'(CHECK_ERR), 18'h0);
        check("end seen", 18'(ends > 0), 18'h1);
        head.play(6'h15, 18'h0);
        settle;
        check("expand code", 18'(MARK_CODE), 18'h15);
        // Reverse pass: the block arrives checksum first and block mark last.
        DIR_REVERSE = 1'b1;
        preamble;
        begin : rev_pass
            logic [17:0] sum;
            sum = 18'h0;
            head.play(6'h08, 18'h0);
            for (k = 0; k < 7; k++) exp_q.push_back(18'($random(seed)));
            foreach (exp_q[i]) sum ^= exp_q[i];
            head.play(6'h3B, sum);
            foreach (exp_q[i]) head.play((i < 2) ? 6'h3B : 6'h38, exp_q[i]);
            head.play(6'h08, 18'h0);
            bn = 18'($random(seed));
            head.play(6'h16, bn);
            drain;
            check("reverse code", 18'(MARK_CODE), 18'h16);
            check("reverse block", 18'(BLOCK_NUM), 18'(bn[11:0]));
            check("reverse sum", 18'(CHECK_ERR), 18'h0);
        end
        // Forward write: the frame after each data mark carries the word, first line high bits.
        DIR_REVERSE = 1'b0;
        WRITE_MODE = 1'b1;
        WR_WORD = 18'($random(seed));
        preamble;
        head.play(6'h16, 18'h0);
        head.play(6'h08, 18'h0);
        repeat (2) head.play(6'h38, 18'h0);
        head.wr_q.delete();
        head.play(6'h38, 18'h0);
        head.play(6'h08, 18'h0);
        for (k = 1; k < 7; k++) check("write line", 18'(head.wr_q[k]), {14'h1, WR_WORD[20-3*k -: 3]});
        // Preformatting turns decoding and writing off.
        @(negedge CLOCK);
        PREFORMAT = 1'b1;
        got_q.delete();
        repeat (3) head.play(6'h38, 18'h5);
        settle;
        check("preformat words", 18'(got_q.size()), 18'h0);
        check("preformat aligned", 18'(ALIGNED), 18'h0);
        check("preformat write", 18'(WR_EN), 18'h0);
        check("block flags", 18'(blocks), 18'h5);
        give_verdict;
    end

    // Guard against a hung run.
    initial begin
        #4000000;
        miscompares++;
        give_verdict;
    end
endmodule : tape_mark_track_decoder_test
